// ---- inc/smsc_pkg.sv ----
`default_nettype none
package smsc_pkg;

  // ---------------------------------------------------------------
  // register map (byte offsets on the 3-bit register port)
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_SBC = 3'h0;
  localparam logic [2:0] ADDR_MSA = 3'h1;
  localparam logic [2:0] ADDR_MSB = 3'h2;
  localparam logic [2:0] ADDR_MSC = 3'h3;
  localparam logic [2:0] ADDR_STAT = 3'h4;

  // ---------------------------------------------------------------
  // standby_control fields and reset values
  // ---------------------------------------------------------------
  localparam int STANDBY_SELECT_BIT_BIT = 7;
  localparam int WAIT_HI = 6;
  localparam int WAIT_LO = 4;
  localparam int RSV1_BIT = 3;
  localparam logic [7:0] SBC_RST = 8'h08;
  localparam logic [7:0] SBC_WMASK = 8'hf8;
  localparam logic [7:0] MSA_RST = 8'h3f;
  localparam logic [7:0] MSB_RST = 8'hff;
  localparam logic [7:0] MSC_RST = 8'hff;

  // module-stop bit positions
  localparam int STOP_XFER = 6;
  localparam int STOP_PTIMER = 5;
  localparam int STOP_PGEN = 3;
  localparam int STOP_ADC = 1;
  localparam int STOP_SER0 = 7;
  localparam int STOP_BRK = 4;
  localparam int STOP_CAN = 3;
  localparam int STOP_MOTOR = 2;

  // ---------------------------------------------------------------
  // timing: one state is one system clock cycle
  // ---------------------------------------------------------------
  localparam int unsigned WAIT_BASE_STATES = 8192;
  localparam int unsigned WAIT_SHORT_STATES = 16;
  localparam int unsigned GATE_DELAY = 2;
  localparam logic [2:0] WAIT_CODE_RSV = 3'h6;
  localparam logic [2:0] WAIT_CODE_SHORT = 3'h7;

  typedef logic [18:0] smsc_cnt_t;
  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_STBY, MODE_WAKE} smsc_mode_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } smsc_bus_s;

  typedef struct packed {
    logic [7:0] c;
    logic [7:0] b;
    logic [7:0] a;
  } smsc_stop_s;

  typedef struct packed {
    logic busy;
    smsc_cnt_t cnt;
    logic done;
  } smsc_tmr_s;

  typedef struct packed {
    smsc_mode_e mode;
    logic [7:0] sbc;
    smsc_stop_s stop;
    logic [7:0] rdata;
    logic [1:0] wsync;
    logic start;
    logic halt;
    logic osc;
    logic clks;
    logic irq_start;
  } smsc_state_s;

  // wait length for a code; the reserved code falls back to the longest wait
  function automatic smsc_cnt_t wait_cycles(input logic [2:0] code,
                                            input int unsigned base,
                                            input int unsigned short_n);
    int unsigned n;
    n = base << 5;
    if (code == WAIT_CODE_SHORT) begin
      n = short_n;
    end else if (code != WAIT_CODE_RSV) begin
      n = base << code;
    end
    return smsc_cnt_t'(n);
  endfunction

endpackage
`default_nettype wire

// ---- design/smsc_wake_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// clock-stabilisation down counter
// ---------------------------------------------------------------
module smsc_wake_timer (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire smsc_pkg::smsc_cnt_t cycles_i,
  output logic done_o
);
  smsc_pkg::smsc_tmr_s s_q, s_d;

  // done pulses one cycle after the count reaches zero
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start_i) begin
      s_d.busy = 1'b1;
      s_d.cnt = cycles_i - smsc_pkg::smsc_cnt_t'(1);
    end else if (s_q.busy) begin
      if (s_q.cnt == '0) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - smsc_pkg::smsc_cnt_t'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_o = s_q.done;
endmodule
`default_nettype wire

// ---- design/smsc_stop_pipe.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// retiming of module-stop bits towards the peripheral clock gates
// ---------------------------------------------------------------
module smsc_stop_pipe #(
  parameter int unsigned DEPTH = smsc_pkg::GATE_DELAY
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire smsc_pkg::smsc_stop_s stop_i,
  output smsc_pkg::smsc_stop_s stop_o
);
  typedef struct packed {
    smsc_pkg::smsc_stop_s [DEPTH-1:0] stage;
  } pipe_s;
  pipe_s s_q, s_d;

  // a short pipe keeps the gate enable off the bus decode timing path
  always_comb begin
    s_d = s_q;
    s_d.stage[0] = stop_i;
    for (int i = 1; i < DEPTH; i++) begin
      s_d.stage[i] = s_q.stage[i-1];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= {DEPTH{smsc_pkg::MSC_RST, smsc_pkg::MSB_RST, smsc_pkg::MSA_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  assign stop_o = s_q.stage[DEPTH-1];
endmodule
`default_nettype wire

// ---- design/smsc_top.sv ----
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE_01] standby select bit 7 resets 0; 0 picks sleep, 1 picks software standby
// [RULE_02] standby select bit never changed by hardware on interrupt wake-up
// [RULE_03] software clears standby select by writing 0; no self-clear
// [RULE_04] wait field bits 6..4 resets 000, sets wake clock-stabilisation wait
// [RULE_05] codes 000..101 give 8192 doubling up to 262144 states
// [RULE_06] code 111 gives 16 states; code 110 reserved, not to be used
// [RULE_07] with crystal, software picks a wait of at least about 8 ms
// [RULE_08] with external clock, software picks a wait of at least 2 ms
// [RULE_09] bit 3 reserved, reads 1 after reset, software writes only 1
// [RULE_10] bits 2..0 always read 0, writes ignored
// [RULE_11] three 8-bit module-stop registers A, B, C, fully read/write
// [RULE_12] stop bit 1 halts its peripheral, 0 resumes it
// [RULE_13] A bit 6 stops transfer controller, resets 0
// [RULE_14] A bits 5, 3, 1: pulse timer, pulse generator, converter; reset 1
// [RULE_15] B bits 7, 6, 5: serial ports 0..2; reset 1
// [RULE_16] C bits 4, 3, 2: break, CAN, motor timer; reset 1
// [RULE_17] A bit 7 read/write, resets 0, software writes 0
// [RULE_18] unassigned stop bits read/write, reset 1, software writes 1
// [RULE_19] after reset the device runs at full speed, no low-power mode
// [RULE_20] in sleep the processor halts, peripherals keep running
// [RULE_21] interrupt wake: oscillator first, clocks after wait, then interrupt handling
// [RULE_22] peripheral clock gated or resumed a few cycles after stop bit write
module smsc_top #(
  parameter int unsigned WAIT_BASE_CYC = smsc_pkg::WAIT_BASE_STATES,
  parameter int unsigned WAIT_SHORT_CYC = smsc_pkg::WAIT_SHORT_STATES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire smsc_pkg::smsc_bus_s bus_i,
  input wire logic sleep_req_i,
  input wire logic irq_i,
  input wire logic ext_wake_i,
  output logic [7:0] rdata_o,
  output smsc_pkg::smsc_mode_e mode_o,
  output logic cpu_halt_o,
  output logic osc_run_o,
  output logic clk_supply_o,
  output logic irq_start_o,
  output smsc_pkg::smsc_stop_s periph_stop_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  smsc_pkg::smsc_state_s s_q, s_d;
  logic wait_done;
  smsc_pkg::smsc_cnt_t wait_len;
  smsc_pkg::smsc_state_s rst_val;
  // cycles from the second sampled wake cycle to the run cycle
  localparam int SHORT_GAP = int'(WAIT_SHORT_CYC) + 1;

  // everything comes up in run mode with documented register values
  always_comb begin
    rst_val = '0;
    rst_val.mode = smsc_pkg::MODE_RUN; // see [RULE_19]
    rst_val.sbc = smsc_pkg::SBC_RST; // see [RULE_01] see [RULE_04] see [RULE_09]
    rst_val.stop.a = smsc_pkg::MSA_RST; // see [RULE_13] see [RULE_14] see [RULE_17]
    rst_val.stop.b = smsc_pkg::MSB_RST; // see [RULE_15] see [RULE_18]
    rst_val.stop.c = smsc_pkg::MSC_RST; // see [RULE_16]
    rst_val.osc = 1'b1;
    rst_val.clks = 1'b1;
  end

  // wait length decoded from the stored field
  assign wait_len = smsc_pkg::wait_cycles(s_q.sbc[smsc_pkg::WAIT_HI:smsc_pkg::WAIT_LO],
                                          WAIT_BASE_CYC, WAIT_SHORT_CYC); // see [RULE_05] see [RULE_06]

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.irq_start = 1'b0;
    s_d.rdata = 8'h00;
    // external wake pin crosses in through two flops
    s_d.wsync = {s_q.wsync[0], ext_wake_i};

    // register writes; only software ever touches the stored bits
    if (bus_i.wr) begin
      case (bus_i.addr)
        smsc_pkg::ADDR_SBC: begin
          s_d.sbc = bus_i.wdata & smsc_pkg::SBC_WMASK; // see [RULE_03] see [RULE_10]
        end
        smsc_pkg::ADDR_MSA: begin
          s_d.stop.a = bus_i.wdata; // see [RULE_11] see [RULE_12]
        end
        smsc_pkg::ADDR_MSB: begin
          s_d.stop.b = bus_i.wdata; // see [RULE_11]
        end
        smsc_pkg::ADDR_MSC: begin
          s_d.stop.c = bus_i.wdata; // see [RULE_11]
        end
        default: begin
        end
      endcase
    end

    // read data valid only in the cycle after the strobe
    if (bus_i.rd) begin
      case (bus_i.addr)
        smsc_pkg::ADDR_SBC: s_d.rdata = s_q.sbc & smsc_pkg::SBC_WMASK; // see [RULE_10]
        smsc_pkg::ADDR_MSA: s_d.rdata = s_q.stop.a;
        smsc_pkg::ADDR_MSB: s_d.rdata = s_q.stop.b;
        smsc_pkg::ADDR_MSC: s_d.rdata = s_q.stop.c;
        smsc_pkg::ADDR_STAT: s_d.rdata = {6'h00, s_q.mode};
        default: s_d.rdata = 8'h00;
      endcase
    end

    // low-power sequencer
    case (s_q.mode)
      smsc_pkg::MODE_RUN: begin
        if (sleep_req_i) begin
          if (s_q.sbc[smsc_pkg::STANDBY_SELECT_BIT_BIT]) begin
            s_d.mode = smsc_pkg::MODE_STBY; // see [RULE_01]
          end else begin
            s_d.mode = smsc_pkg::MODE_SLEEP; // see [RULE_01]
          end
        end
      end
      smsc_pkg::MODE_SLEEP: begin
        // any interrupt ends sleep; peripherals never stopped
        if (irq_i) begin
          s_d.mode = smsc_pkg::MODE_RUN; // see [RULE_20]
        end
      end
      smsc_pkg::MODE_STBY: begin
        // only the external pin can wake; restart the oscillator first
        if (s_q.wsync[1]) begin
          s_d.mode = smsc_pkg::MODE_WAKE; // see [RULE_21]
          s_d.start = 1'b1;
        end
      end
      smsc_pkg::MODE_WAKE: begin
        // the select bit is left alone here on purpose
        if (wait_done) begin
          s_d.mode = smsc_pkg::MODE_RUN; // see [RULE_02] see [RULE_21]
          s_d.irq_start = 1'b1;
        end
      end
      default: begin
        s_d.mode = smsc_pkg::MODE_RUN;
      end
    endcase

    // outputs follow the next mode so they stay aligned with mode_o
    s_d.halt = (s_d.mode != smsc_pkg::MODE_RUN); // see [RULE_20]
    s_d.osc = (s_d.mode != smsc_pkg::MODE_STBY); // see [RULE_21]
    s_d.clks = (s_d.mode != smsc_pkg::MODE_STBY) && (s_d.mode != smsc_pkg::MODE_WAKE);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '{mode: smsc_pkg::MODE_RUN, sbc: smsc_pkg::SBC_RST,
               stop: '{c: smsc_pkg::MSC_RST, b: smsc_pkg::MSB_RST, a: smsc_pkg::MSA_RST},
               rdata: 8'h00, wsync: 2'b00, start: 1'b0, halt: 1'b0,
               osc: 1'b1, clks: 1'b1, irq_start: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // sub-blocks
  // ---------------------------------------------------------------
  // counting runs on the system clock, so the wait only
  // begins once the oscillator is declared running again
  smsc_wake_timer u_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(s_q.start),
    .cycles_i(wait_len),
    .done_o(wait_done)
  );

  // peripheral gate enables lag the register by a fixed two cycles
  smsc_stop_pipe #(
    .DEPTH(smsc_pkg::GATE_DELAY)
  ) u_gate (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .stop_i(s_q.stop),
    .stop_o(periph_stop_o) // see [RULE_22]
  );

  // outputs straight from the state register
  assign rdata_o = s_q.rdata;
  assign mode_o = s_q.mode;
  assign cpu_halt_o = s_q.halt;
  assign osc_run_o = s_q.osc;
  assign clk_supply_o = s_q.clks;
  assign irq_start_o = s_q.irq_start;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence seq_run_sleep_req;
    (s_q.mode == smsc_pkg::MODE_RUN) && sleep_req_i;
  endsequence

  sequence seq_wake_end;
    (s_q.mode == smsc_pkg::MODE_WAKE) ##1 (s_q.mode == smsc_pkg::MODE_RUN);
  endsequence

  sequence seq_short_wake_start;
    $rose(s_q.mode == smsc_pkg::MODE_WAKE) &&
      (s_q.sbc[smsc_pkg::WAIT_HI:smsc_pkg::WAIT_LO] == smsc_pkg::WAIT_CODE_SHORT);
  endsequence

  a_sleep_entry: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE_01]
    seq_run_sleep_req and !s_q.sbc[smsc_pkg::STANDBY_SELECT_BIT_BIT] |=> (mode_o == smsc_pkg::MODE_SLEEP)
      && cpu_halt_o && osc_run_o)
    else $error("sleep not entered with select bit clear");

  a_standby_entry: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE_01]
    seq_run_sleep_req and s_q.sbc[smsc_pkg::STANDBY_SELECT_BIT_BIT] |=> (mode_o == smsc_pkg::MODE_STBY)
      && !osc_run_o && !clk_supply_o)
    else $error("standby not entered with select bit set");

  a_select_kept: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE_02]
    seq_wake_end |-> s_q.sbc[smsc_pkg::STANDBY_SELECT_BIT_BIT] && $stable(s_q.sbc))
    else $error("select bit altered on wake-up");

  a_short_wait: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE_06]
    seq_short_wake_start |-> (s_q.mode == smsc_pkg::MODE_WAKE)[*2]
      ##SHORT_GAP (s_q.mode == smsc_pkg::MODE_RUN) && irq_start_o)
    else $error("short wake wait has the wrong length");

  // the whole state must sit at its start values in the first cycle out of reset
  a_reset_state: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE_19]
    $rose(nrst_i) |-> (s_q == rst_val))
    else $error("state not at start values after reset");

  a_irq_after_wait: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE_21]
    seq_wake_end |-> irq_start_o && clk_supply_o ##1 !irq_start_o)
    else $error("interrupt start not a single pulse at wake end");

  a_field_write_only: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE_04]
    !(bus_i.wr && bus_i.addr == smsc_pkg::ADDR_SBC) |=> $stable(s_q.sbc))
    else $error("standby control changed without a write");

  a_low_bits_zero: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE_10]
    bus_i.rd && bus_i.addr == smsc_pkg::ADDR_SBC |=> rdata_o[2:0] == 3'b000
      && rdata_o[7:3] == $past(s_q.sbc[7:3]))
    else $error("standby control read back wrong");

  a_stop_write: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE_11]
    bus_i.wr && bus_i.addr == smsc_pkg::ADDR_MSB |=> s_q.stop.b == $past(bus_i.wdata))
    else $error("module-stop write not stored");

  a_gate_delay: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE_22]
    $changed(s_q.stop) |-> ##2 periph_stop_o == $past(s_q.stop, 2))
    else $error("peripheral stop not applied two cycles after write");

  a_sleep_halt: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE_20]
    (s_q.mode == smsc_pkg::MODE_SLEEP) |-> cpu_halt_o && clk_supply_o && osc_run_o)
    else $error("sleep must halt only the processor");

  a_sleep_exit: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE_20]
    (s_q.mode == smsc_pkg::MODE_SLEEP) && irq_i |=> !cpu_halt_o ##0
      (mode_o == smsc_pkg::MODE_RUN))
    else $error("sleep not left on interrupt");

endmodule
`default_nettype wire

// ---- test/smsc_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// one compare: case equality so an unknown never counts as a match
`define CHK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb;
  // ---------------------------------------------------------------
  // signals and design instance
  // ---------------------------------------------------------------
  // shortened so every wait code fits the run; real software must still
  // pick a wait covering oscillator or clock settling time
  localparam int unsigned BASE = 32;
  localparam int unsigned SHORT = 4;
  localparam int CEILING = 20000; // longest wait is 1024 cycles, all tests well under this
  logic clk_i;
  logic nrst_i;
  smsc_pkg::smsc_bus_s bus;
  logic sleep_req;
  logic irq;
  logic ext_wake;
  logic [7:0] rdata;
  smsc_pkg::smsc_mode_e mode;
  logic halt;
  logic osc;
  logic clks;
  logic irq_start;
  smsc_pkg::smsc_stop_s pstop;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  smsc_top #(.WAIT_BASE_CYC(BASE), .WAIT_SHORT_CYC(SHORT)) DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus), .sleep_req_i(sleep_req),
    .irq_i(irq), .ext_wake_i(ext_wake), .rdata_o(rdata), .mode_o(mode),
    .cpu_halt_o(halt), .osc_run_o(osc), .clk_supply_o(clks),
    .irq_start_o(irq_start), .periph_stop_o(pstop));

  // ---------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // a hung wait loop would otherwise run forever
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == CEILING) begin
      errors++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask

  // read data must stand in the one cycle after the strobe and drop to 0 after
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_i);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1;
    `CHK(what, exp, rdata)
    @(posedge clk_i);
    #1;
    `CHK("rdata_idle", 8'h00, rdata)
  endtask

  task automatic chk_state(input smsc_pkg::smsc_mode_e m, input logic h, input logic o,
                           input logic c);
    `CHK("mode", m, mode)
    `CHK("cpu_halt", h, halt)
    `CHK("osc_run", o, osc)
    `CHK("clk_supply", c, clks)
  endtask

  task automatic pulse_sleep();
    @(posedge clk_i);
    sleep_req <= 1'b1;
    @(posedge clk_i);
    sleep_req <= 1'b0;
    #1;
  endtask

  task automatic pulse_irq();
    @(posedge clk_i);
    irq <= 1'b1;
    @(posedge clk_i);
    irq <= 1'b0;
    #1;
  endtask

  // reset, then every register and every output except irq_start_o must be back at its start value
  task automatic do_reset();
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1;
    chk_state(smsc_pkg::MODE_RUN, 1'b0, 1'b1, 1'b1);
    `CHK("stop_out", {8'hff, 8'hff, 8'h3f}, pstop)
    rd_chk(smsc_pkg::ADDR_SBC, 8'h08, "sbc_rst");
    rd_chk(smsc_pkg::ADDR_MSA, 8'h3f, "msa_rst");
    rd_chk(smsc_pkg::ADDR_MSB, 8'hff, "msb_rst");
    rd_chk(smsc_pkg::ADDR_MSC, 8'hff, "msc_rst");
  endtask

  // sleep keeps oscillator and chip clocks, any interrupt returns to run
  task automatic do_sleep();
    pulse_sleep();
    chk_state(smsc_pkg::MODE_SLEEP, 1'b1, 1'b1, 1'b1);
    pulse_irq();
    chk_state(smsc_pkg::MODE_RUN, 1'b0, 1'b1, 1'b1);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] val [3];
    logic [2:0] adr [3];
    smsc_pkg::smsc_stop_s exp_stop;
    int n;
    int k;
    nrst_i = 1'b0;
    bus = '0;
    sleep_req = 1'b0;
    irq = 1'b0;
    ext_wake = 1'b0;
    // reserved stop bits written as software must: A7 zero, the rest one
    val = '{8'h7d, 8'h1f, 8'he3};
    adr = '{smsc_pkg::ADDR_MSA, smsc_pkg::ADDR_MSB, smsc_pkg::ADDR_MSC};
    do_reset();
    do_sleep();
    // low three bits are read-only zero, bit 3 holds what software writes
    wr_reg(smsc_pkg::ADDR_SBC, 8'h7f);
    rd_chk(smsc_pkg::ADDR_SBC, 8'h78, "sbc_low");
    wr_reg(smsc_pkg::ADDR_SBC, 8'h08);
    // unmapped and status places ignore writes
    wr_reg(3'h5, 8'h5a);
    rd_chk(3'h5, 8'h00, "unmapped");
    wr_reg(smsc_pkg::ADDR_STAT, 8'hff);
    rd_chk(smsc_pkg::ADDR_STAT, 8'h00, "status");
    // module stop: each write reaches the gates within three cycles
    exp_stop = {8'hff, 8'hff, 8'h3f};
    for (int i = 0; i < 3; i++) begin
      wr_reg(adr[i], val[i]);
      #1;
      `CHK("stop_hold", exp_stop, pstop)
      exp_stop[8*i +: 8] = val[i];
      repeat (3) @(posedge clk_i);
      #1;
      `CHK("stop_gate", exp_stop, pstop)
      rd_chk(adr[i], val[i], "stop_rw");
    end
    // standby for every wait code; the reserved one must fall back to the longest
    for (int code = 0; code < 8; code++) begin
      n = (code == 7) ? SHORT : (code == 6) ? (BASE << 5) : (BASE << code);
      wr_reg(smsc_pkg::ADDR_SBC, {1'b1, code[2:0], 4'h8});
      pulse_sleep();
      chk_state(smsc_pkg::MODE_STBY, 1'b1, 1'b0, 1'b0);
      pulse_irq();
      chk_state(smsc_pkg::MODE_STBY, 1'b1, 1'b0, 1'b0);
      @(posedge clk_i);
      ext_wake <= 1'b1;
      k = 0;
      while (mode !== smsc_pkg::MODE_WAKE && k < 8) begin
        @(posedge clk_i);
        #1;
        k++;
      end
      chk_state(smsc_pkg::MODE_WAKE, 1'b1, 1'b1, 1'b0);
      k = 0;
      while (mode === smsc_pkg::MODE_WAKE && k < 2000) begin
        @(posedge clk_i);
        #1;
        k++;
      end
      `CHK("wake_len", n + 2, k)
      `CHK("irq_start", 1'b1, irq_start)
      chk_state(smsc_pkg::MODE_RUN, 1'b0, 1'b1, 1'b1);
      @(posedge clk_i);
      #1;
      `CHK("irq_start_end", 1'b0, irq_start)
      ext_wake <= 1'b0;
      rd_chk(smsc_pkg::ADDR_SBC, {1'b1, code[2:0], 4'h8}, "sbc_keep");
    end
    // only a software write of zero brings sleep back
    wr_reg(smsc_pkg::ADDR_SBC, 8'h08);
    do_sleep();
    // a second reset in mid-run restores everything
    do_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
